/* shared/mscsp_pkg.sv */
// Package for the motion system control, status and pin I/O register block
package mscsp_pkg;
   // Register word width and pin count
   localparam int REG_W = 12;
   localparam int PIO_N = 6;
   localparam int ADDR_W = 4;

   // Register addresses on the 4-bit register port
   localparam logic [3:0] ADDR_PIO_CTRL = 4'hB;
   localparam logic [3:0] ADDR_PIO_DATA = 4'hC;
   localparam logic [3:0] ADDR_SYS_CTRL = 4'hD;
   localparam logic [3:0] ADDR_SYS_STAT = 4'hE;

   // System control field positions
   localparam int SC_AUX_SEL0 = 0;
   localparam int SC_AUX_SEL1 = 1;
   localparam int SC_U_EN = 3;
   localparam int SC_AUX_EN = 4;
   localparam int SC_CLK_DIV2 = 5;
   localparam int SC_PARK_IE = 6;
   localparam int SC_ADC_IE = 7;
   localparam int SC_IRQ_LEVEL = 8;
   localparam int SC_ROT_33 = 10;
   // Writable bits of system control; others read zero
   localparam logic [11:0] SC_WMASK = 12'h5FB;
   localparam logic [11:0] SC_RESET = 12'h000;

   // System status field positions
   localparam int ST_ADC_DONE = 0;
   localparam int ST_XFORM_DONE = 1;
   localparam int ST_PIO_CHANGE = 2;
   localparam int ST_ROT_VALID = 4;
   localparam int ST_IRQ_MINE = 11;

   // Pin I/O control layout
   localparam int PC_DIR_LSB = 0;
   localparam int PC_IE_LSB = 6;
   localparam logic [11:0] PC_RESET = 12'h000;
   localparam logic [5:0] PIO_DATA_RESET = 6'h00;

   // Converted channel set
   typedef struct packed {
      logic       conv_u;
      logic       conv_v;
      logic       conv_w;
      logic       conv_aux;
      logic [1:0] aux_sel;
      logic       three_phase;
   } mscsp_chan_s;

   // Register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [11:0] wdata;
      logic        wr;
      logic        rd;
   } mscsp_req_s;
endpackage

/* verilog/mscsp_top.sv */
// Motion system control, status, IRQ and pin I/O control block
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps

module mscsp_top
   import mscsp_pkg::*;
#(
   parameter int NPIO = PIO_N
) (
   input  wire logic              I_CLOCK,
   input  wire logic              I_SYS_RST,
   input  wire logic [3:0]        I_ADDR,
   input  wire logic [11:0]       I_WDATA,
   input  wire logic              I_WR,
   input  wire logic              I_RD,
   output logic      [11:0]       O_RDATA,
   input  wire logic              I_ADC_DONE,
   input  wire logic              I_XFORM_START,
   input  wire logic              I_XFORM_DONE,
   input  wire logic [NPIO-1:0]   I_PIO,
   output logic      [NPIO-1:0]   O_PIO,
   output logic      [NPIO-1:0]   O_PIO_OE,
   output logic                   O_IRQ_N,
   output logic                   O_SYS_CE,
   output mscsp_chan_s            O_CHAN,
   output logic                   O_ROT_33
);

   // Register state
   logic [11:0]     sys_ctrl_r;
   logic [11:0]     pio_ctrl_r;
   logic [NPIO-1:0] pio_out_r;
   logic            st_adc_r;
   logic            st_xf_r;
   logic            st_pio_r;
   logic            st_irq_r;
   logic            st_valid_r;
   logic            xf_started_r;
   logic [NPIO-1:0] pio_s1_r;
   logic [NPIO-1:0] pio_s2_r;
   logic [NPIO-1:0] pio_prev_r;
   logic            div_ph_r;
   logic            ce_r;
   logic            irq_n_r;
   logic            lvl_hold_r;
   logic [11:0]     rdata_r;
   mscsp_chan_s     chan_r;
   logic            rot33_r;

   // Address decode
   mscsp_req_s req;
   wire        wr_sc;
   wire        wr_pc;
   wire        wr_pd;
   wire        rd_st;
   assign req   = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
   assign wr_sc = req.wr && (req.addr == ADDR_SYS_CTRL);
   assign wr_pc = req.wr && (req.addr == ADDR_PIO_CTRL);
   assign wr_pd = req.wr && (req.addr == ADDR_PIO_DATA);
   assign rd_st = req.rd && (req.addr == ADDR_SYS_STAT);

   // Pin direction and change enables
   wire [NPIO-1:0] pio_dir;
   wire [NPIO-1:0] pio_ie;
   assign pio_dir = pio_ctrl_r[PC_DIR_LSB +: NPIO];
   assign pio_ie  = pio_ctrl_r[PC_IE_LSB +: NPIO];

   // Event qualification; events only count on system clock enables
   wire ev_adc;
   wire ev_xf;
   wire ev_pio;
   wire ev_any;
   assign ev_adc = ce_r && I_ADC_DONE && sys_ctrl_r[SC_ADC_IE];
   assign ev_xf  = ce_r && I_XFORM_DONE && sys_ctrl_r[SC_PARK_IE];
   // Per-pin change detect; an output pin never qualifies, whatever its enable says
   wire [NPIO-1:0] pin_moved;
   wire [NPIO-1:0] pin_armed;
   wire [NPIO-1:0] pin_event;
   genvar gp;
   generate
      for (gp = 0; gp < NPIO; gp++) begin : g_pin
         assign pin_moved[gp] = pio_s2_r[gp] ^ pio_prev_r[gp];
         assign pin_armed[gp] = pio_ie[gp] && !pio_dir[gp];
         assign pin_event[gp] = pin_moved[gp] && pin_armed[gp];
      end
   endgenerate
   assign ev_pio = ce_r && |pin_event;
   assign ev_any = ev_adc || ev_xf || ev_pio;

   // Status next values: set wins over read clear
   wire st_adc_nxt;
   wire st_xf_nxt;
   wire st_pio_nxt;
   wire st_irq_nxt;
   assign st_adc_nxt = ev_adc || (st_adc_r && !rd_st);
   assign st_xf_nxt  = ev_xf  || (st_xf_r  && !rd_st);
   assign st_pio_nxt = ev_pio || (st_pio_r && !rd_st);
   assign st_irq_nxt = ev_any || (st_irq_r && !rd_st);

   // IRQ level hold: set by event, released by status read
   wire lvl_hold_nxt;
   wire irq_n_nxt;
   assign lvl_hold_nxt = ev_any || (lvl_hold_r && !rd_st);
   // Edge format: one system-clock period low, stretched over a disabled fast cycle
   wire irq_edge_low;
   wire irq_level_low;
   assign irq_edge_low  = ev_any || (!irq_n_r && !ce_r);
   assign irq_level_low = lvl_hold_nxt;
   assign irq_n_nxt     = sys_ctrl_r[SC_IRQ_LEVEL] ? !irq_level_low : !irq_edge_low;

   // Status read view; valid bit held zero until a transform starts
   wire [11:0] status_word;
   wire        valid_shown;
   assign valid_shown = st_valid_r && xf_started_r;
   assign status_word = (REG_W'(st_adc_r) << ST_ADC_DONE)
                      | (REG_W'(st_xf_r) << ST_XFORM_DONE)
                      | (REG_W'(st_pio_r) << ST_PIO_CHANGE)
                      | (REG_W'(valid_shown) << ST_ROT_VALID)
                      | (REG_W'(st_irq_r) << ST_IRQ_MINE);

   // Read mux, data stands in the cycle after the strobe
   wire [11:0] rd_mux;
   assign rd_mux = !req.rd                      ? 12'h000
                 : (req.addr == ADDR_SYS_CTRL)  ? sys_ctrl_r
                 : (req.addr == ADDR_SYS_STAT)  ? status_word
                 : (req.addr == ADDR_PIO_CTRL)  ? pio_ctrl_r
                 : (req.addr == ADDR_PIO_DATA)  ? {{(12-NPIO){1'b0}}, pio_s2_r}
                 : 12'h000;

   // Channel selection decode
   mscsp_chan_s chan_nxt;
   assign chan_nxt.aux_sel     = {sys_ctrl_r[SC_AUX_SEL0], sys_ctrl_r[SC_AUX_SEL1]};
   assign chan_nxt.conv_u      = sys_ctrl_r[SC_U_EN];
   assign chan_nxt.conv_v      = 1'b1;
   assign chan_nxt.conv_w      = 1'b1;
   assign chan_nxt.conv_aux    = sys_ctrl_r[SC_AUX_EN];
   assign chan_nxt.three_phase = sys_ctrl_r[SC_U_EN];

   // Clock divider: enable every cycle, or every other cycle when halved
   wire div_ph_nxt;
   wire ce_nxt;
   assign div_ph_nxt = sys_ctrl_r[SC_CLK_DIV2] ? !div_ph_r : 1'b0;
   assign ce_nxt     = !sys_ctrl_r[SC_CLK_DIV2] || div_ph_r;

   // Next values of the host-writable registers; reserved control bits stay zero
   wire [11:0]     sys_ctrl_nxt;
   wire [11:0]     pio_ctrl_nxt;
   wire [NPIO-1:0] pio_out_nxt;
   assign sys_ctrl_nxt = wr_sc ? (req.wdata & SC_WMASK) : sys_ctrl_r;
   assign pio_ctrl_nxt = wr_pc ? req.wdata : pio_ctrl_r;
   assign pio_out_nxt  = wr_pd ? req.wdata[NPIO-1:0] : pio_out_r;

   // Transform progress: a start clears valid, a finish sets it, reads leave it
   wire st_valid_nxt;
   wire xf_started_nxt;
   assign xf_started_nxt = I_XFORM_START || xf_started_r;
   assign st_valid_nxt   = I_XFORM_START ? 1'b0 : (I_XFORM_DONE || st_valid_r);

   // Rotation mode follows the control register one cycle later
   wire rot33_nxt;
   assign rot33_nxt = sys_ctrl_r[SC_ROT_33];

   // System control register
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sys_ctrl_r <= SC_RESET;
      end else begin
         sys_ctrl_r <= sys_ctrl_nxt;
      end
   end

   // Pin direction and change-enable register
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pio_ctrl_r <= PC_RESET;
      end else begin
         pio_ctrl_r <= pio_ctrl_nxt;
      end
   end

   // Pin output data; only shows on pins set as outputs
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pio_out_r <= PIO_DATA_RESET;
      end else begin
         pio_out_r <= pio_out_nxt;
      end
   end

   // First synchroniser stage; may go metastable, so only the second stage reads it
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pio_s1_r <= '0;
      end else begin
         pio_s1_r <= I_PIO;
      end
   end

   // Second synchroniser stage
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pio_s2_r <= '0;
      end else begin
         pio_s2_r <= pio_s1_r;
      end
   end

   // Previous sample, taken per system clock so a change is seen once
   // Limitation: a pulse shorter than a system clock may be missed
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pio_prev_r <= '0;
      end else if (ce_r) begin
         pio_prev_r <= pio_s2_r;
      end
   end

   // Conversion-done flag
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         st_adc_r <= 1'b0;
      end else begin
         st_adc_r <= st_adc_nxt;
      end
   end

   // Transformation-done flag
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         st_xf_r <= 1'b0;
      end else begin
         st_xf_r <= st_xf_nxt;
      end
   end

   // Pin change flag
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         st_pio_r <= 1'b0;
      end else begin
         st_pio_r <= st_pio_nxt;
      end
   end

   // Interrupt-from-this-block flag
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         st_irq_r <= 1'b0;
      end else begin
         st_irq_r <= st_irq_nxt;
      end
   end

   // Result-valid flag; a status read never touches it
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         st_valid_r <= 1'b0;
      end else begin
         st_valid_r <= st_valid_nxt;
      end
   end

   // First transform seen; masks the undefined valid bit as zero before it
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         xf_started_r <= 1'b0;
      end else begin
         xf_started_r <= xf_started_nxt;
      end
   end

   // IRQ output, idle high
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= irq_n_nxt;
      end
   end

   // Level-format hold, released by a status read
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         lvl_hold_r <= 1'b0;
      end else begin
         lvl_hold_r <= lvl_hold_nxt;
      end
   end

   // Divider phase
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         div_ph_r <= 1'b0;
      end else begin
         div_ph_r <= div_ph_nxt;
      end
   end

   // System clock enable; one clock tree, the slower rate is only an enable
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ce_r <= 1'b1;
      end else begin
         ce_r <= ce_nxt;
      end
   end

   // Read data; zero outside the cycle after a read strobe
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         rdata_r <= 12'h000;
      end else begin
         rdata_r <= rd_mux;
      end
   end

   // Channel selection output
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         chan_r <= '0;
      end else begin
         chan_r <= chan_nxt;
      end
   end

   // Rotation mode output
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         rot33_r <= 1'b0;
      end else begin
         rot33_r <= rot33_nxt;
      end
   end

   // Outputs come straight from the registers above

   assign O_RDATA  = rdata_r;
   assign O_PIO    = pio_out_r;
   assign O_PIO_OE = pio_ctrl_r[PC_DIR_LSB +: NPIO];
   assign O_IRQ_N  = irq_n_r;
   assign O_SYS_CE = ce_r;
   assign O_CHAN   = chan_r;
   assign O_ROT_33 = rot33_r;

endmodule

/* dv/mscsp_props.sv */
// Port checker for the system control, status and pin block
`timescale 1ns/1ps
module mscsp_props
   import mscsp_pkg::*;
#(
   parameter int NPIO = PIO_N
) (
   input wire logic            I_CLOCK,
   input wire logic            I_SYS_RST,
   input wire logic [3:0]      I_ADDR,
   input wire logic            I_WR,
   input wire logic            I_RD,
   input wire logic [11:0]     O_RDATA,
   input wire logic [NPIO-1:0] O_PIO,
   input wire logic [NPIO-1:0] O_PIO_OE,
   input wire logic            O_SYS_CE,
   input wire mscsp_chan_s     O_CHAN,
   input wire logic            O_ROT_33
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   // Decodes; outputs may lag a write by up to three edges
   wire wr_ctl = I_WR && I_ADDR == ADDR_SYS_CTRL;
   wire wr_pio = I_WR && (I_ADDR == ADDR_PIO_CTRL || I_ADDR == ADDR_PIO_DATA);
   wire rd_st  = I_RD && I_ADDR == ADDR_SYS_STAT;
   chan_mode_a: assert property (O_CHAN.three_phase == O_CHAN.conv_u)
      else $error("three-phase mode differs from U enable");
   chan_vw_a: assert property (O_CHAN.conv_v == O_CHAN.conv_w)
      else $error("V and W selection differ");
   ce_half_a: assert property (!O_SYS_CE |=> O_SYS_CE)
      else $error("clock enable low twice in a row");
   stat_any_a: assert property ($past(rd_st) |-> O_RDATA[11] == |O_RDATA[2:0])
      else $error("device flag disagrees with sources");
   rot_hold_a: assert property (
      !($past(wr_ctl) || $past(wr_ctl, 2) || $past(wr_ctl, 3)) |-> $stable(O_ROT_33))
      else $error("rotation mode moved without a write");
   sel_hold_a: assert property (
      !($past(wr_ctl) || $past(wr_ctl, 2) || $past(wr_ctl, 3)) |-> $stable(O_CHAN.aux_sel))
      else $error("aux select moved without a write");
   oe_hold_a: assert property (
      !($past(wr_pio) || $past(wr_pio, 2) || $past(wr_pio, 3)) |-> $stable(O_PIO_OE))
      else $error("pin direction moved without a write");
   pio_hold_a: assert property (
      !($past(wr_pio) || $past(wr_pio, 2) || $past(wr_pio, 3)) |-> $stable(O_PIO))
      else $error("pin data moved without a write");
endmodule
bind mscsp_top mscsp_props #(.NPIO(NPIO)) u_props (
   .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WR(I_WR),
   .I_RD(I_RD), .O_RDATA(O_RDATA), .O_PIO(O_PIO), .O_PIO_OE(O_PIO_OE),
   .O_SYS_CE(O_SYS_CE), .O_CHAN(O_CHAN), .O_ROT_33(O_ROT_33));

/* dv/mscsp_pins.sv */
// Outside world of the six digital pins
`timescale 1ns/1ps
module mscsp_pins #(
   parameter int N = 6
) (
   input  wire logic [N-1:0] i_oe,
   input  wire logic [N-1:0] i_dout,
   input  wire logic [N-1:0] i_ext,
   output logic      [N-1:0] o_level
);
   // Driven pins carry block data, the rest the outside source
   assign o_level = (i_oe & i_dout) | (~i_oe & i_ext);
endmodule

/* dv/mscsp_top_bench.sv */
// Register-level bench for the system control, status and pin block
`timescale 1ns/1ps
module mscsp_top_bench;
   import mscsp_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic        adc = 1'b0, xs = 1'b0, xd = 1'b0, irq_n, ce, rot;
   logic [3:0]  addr = 4'h0;
   logic [11:0] wdata = 12'h000, rdata, got;
   logic [5:0]  ext = 6'h00, lvl, pio, oe;
   mscsp_chan_s chan;
   int          fail_count = 0, n_checks = 0, cnt;
   // 250 MHz clock
   always #2 clk = ~clk;
   mscsp_top DUT (.I_CLOCK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ADC_DONE(adc), .I_XFORM_START(xs),
      .I_XFORM_DONE(xd), .I_PIO(lvl), .O_PIO(pio), .O_PIO_OE(oe), .O_IRQ_N(irq_n),
      .O_SYS_CE(ce), .O_CHAN(chan), .O_ROT_33(rot));
   mscsp_pins u_pins (.i_oe(oe), .i_dout(pio), .i_ext(ext), .o_level(lvl));
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [11:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rchk(input logic [3:0] a, input logic [11:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic ev(input logic a, input logic x, input logic s);
      @(posedge clk);
      adc <= a;
      xd <= x;
      xs <= s;
      @(posedge clk);
      {adc, xd, xs} <= 3'b000;
   endtask
   // Counts low IRQ cycles, starting with the current one
   task automatic lows(input int n);
      cnt = 0;
      repeat (n) begin
         #1 if (irq_n !== 1'b1) cnt++;
         @(posedge clk);
      end
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk(ADDR_SYS_CTRL, SC_RESET);
      rchk(ADDR_PIO_CTRL, PC_RESET);
      rchk(ADDR_SYS_STAT, 12'h000);
      rchk(4'h0, 12'h000);
      wr_reg(ADDR_SYS_CTRL, 12'hFFF);
      rchk(ADDR_SYS_CTRL, SC_WMASK);
      chk({11'h0, rot}, 12'h001);
      for (int i = 0; i < 4; i++) begin
         wr_reg(ADDR_SYS_CTRL, 12'(i * 9));
         repeat (2) @(posedge clk);
         #1 chk({5'h0, chan}, {5'h0, i[0], 2'b11, i[1], i[0], i[1], i[0]});
      end
      wr_reg(ADDR_SYS_CTRL, 12'h080);
      ev(1'b1, 1'b0, 1'b0);
      lows(6);
      chk(12'(cnt), 12'h001);
      rchk(ADDR_SYS_STAT, 12'h801);
      rchk(ADDR_SYS_STAT, 12'h000);
      wr_reg(ADDR_SYS_CTRL, 12'h000);
      ev(1'b1, 1'b1, 1'b0);
      lows(6);
      chk(12'(cnt), 12'h000);
      rchk(ADDR_SYS_STAT, 12'h000);
      wr_reg(ADDR_SYS_CTRL, 12'h140);
      ev(1'b0, 1'b0, 1'b1);
      ev(1'b0, 1'b1, 1'b0);
      lows(8);
      chk(12'(cnt), 12'h008);
      rchk(ADDR_SYS_STAT, 12'h812);
      @(posedge clk);
      lows(4);
      chk(12'(cnt), 12'h000);
      rchk(ADDR_SYS_STAT, 12'h010);
      // Divided clock: enable high every other cycle; host rule at 250 MHz
      wr_reg(ADDR_SYS_CTRL, 12'h0A0);
      cnt = 0;
      repeat (8) begin
         @(posedge clk);
         #1 if (ce === 1'b1) cnt++;
      end
      chk(12'(cnt), 12'h004);
      // Edge pulse in divided mode lasts one system clock, two fast cycles
      if (ce === 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      adc <= 1'b1;
      @(posedge clk);
      adc <= 1'b0;
      lows(6);
      chk(12'(cnt), 12'h002);
      rchk(ADDR_SYS_STAT, 12'h811);
      wr_reg(ADDR_SYS_CTRL, 12'h000);
      wr_reg(ADDR_PIO_CTRL, 12'h0C1);
      wr_reg(ADDR_PIO_DATA, 12'h001);
      rchk(ADDR_PIO_CTRL, 12'h0C1);
      chk({oe, lvl}, 12'h041);
      wr_reg(ADDR_PIO_DATA, 12'h000);
      repeat (6) @(posedge clk);
      rchk(ADDR_SYS_STAT, 12'h010);
      ext <= 6'h04;
      repeat (6) @(posedge clk);
      rchk(ADDR_SYS_STAT, 12'h010);
      ext <= 6'h06;
      repeat (6) @(posedge clk);
      rchk(ADDR_SYS_STAT, 12'h814);
      rchk(ADDR_PIO_DATA, 12'h006);
      // Flag raised in the very cycle of a clearing read
      wr_reg(ADDR_SYS_CTRL, 12'h080);
      @(posedge clk);
      rd <= 1'b1;
      addr <= ADDR_SYS_STAT;
      adc <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      adc <= 1'b0;
      #1 chk(rdata, 12'h010);
      rchk(ADDR_SYS_STAT, 12'h811);
      // Reset in mid-run returns status and pin control to idle
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rchk(ADDR_SYS_STAT, 12'h000);
      rchk(ADDR_PIO_CTRL, PC_RESET);
      wrap_up;
   end
   // Hang guard
   initial begin
      #200000;
      fail_count++;
      wrap_up;
   end
endmodule
